/* File: lac_access_ack.sv */
// access levels, cold start reset dialog and latch acknowledge control
// assumes synchronous inputs, panel key inputs already debounced
`timescale 1ns/1ns

// Overview of operation
// - unlocked area permits its own and all lower area actions without password
// - panel unlock grants panel operations only; sessions unlock separately
// - no panel key for timeout returns panel to read-only, discards edits
// - inactivity timeout configurable from 20 to 3600 seconds
// - a session unlock applies to that session only
// - clear key held at cold start opens reset dialog, panel only
// - factory reset restores parameters, clears records and counters, restarts
// - password reset restores default passwords
// - reset option: both, factory only, or dialog disabled
// - leds, outputs, scada signals and trip command latch until acknowledged
// - individual signal rising clears its own object latch
// - group signal rising clears the whole group latches
// - new protection alarm clears auto-ack leds only
// - collective commands each clear one set of latches, the all command every set
// - clear key press clears all latch groups at once
// - latch clears only when its setting signal is inactive
// - remote enable off leaves only manual panel acknowledge working
// - latched output releases only after its off-delay elapsed
module lac_access_ack #(
  parameter int MS_CYCLES = lac_pkg::MS_CYCLES
) (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // panel
  input wire logic key_press,
  input wire logic clear_key,
  input wire logic edit_dirty,
  input wire logic cold_start,
  input wire logic dlg_factory_yes,
  input wire logic dlg_pw_yes,
  input wire logic dlg_exit,
  output logic dialog_active,
  output logic factory_defaults,
  output logic records_clear,
  output logic counters_clear,
  output logic restart_req,
  output logic pw_default,
  output logic edit_discard,
  output logic lock_open,
  // access requests
  input wire logic unlock_req,
  input wire logic lock_req,
  input wire logic [2:0] unlock_src,
  input wire logic [2:0] unlock_area,
  input wire logic [2:0] perm_src,
  input wire logic [2:0] perm_area,
  output logic perm_grant,
  // latched objects
  input wire logic [16:0] obj_src,
  input wire logic [16:0] ack_ind,
  input wire logic [2:0] ack_grp,
  input wire logic prot_alarm,
  output logic [16:0] obj_out
);
  typedef enum {DS_IDLE, DS_DIALOG, DS_DONE} lac_dlg_t;

  // strands p1<p2<s3 and c1<c2<s3; read-only needs nothing
  function automatic logic permits(input logic [2:0] have, input logic [2:0] need);
    permits = (need == lac_pkg::LV_RO) || (have == lac_pkg::LV_S3) || (have == need)
      || (have == lac_pkg::LV_P2 && need == lac_pkg::LV_P1)
      || (have == lac_pkg::LV_C2 && need == lac_pkg::LV_C1);
  endfunction

  // merge write data under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    merge = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) merge[b*8 +: 8] = wd[b*8 +: 8];
    end
  endfunction

  logic [31:0] ctrl_reg, ctrl_next;
  logic [11:0] tmo_reg, tmo_next;
  logic [15:0] offdly_reg, offdly_next;
  logic [4:0] cmd_next, cmd_reg;
  logic ack_reg, ack_next;
  logic [31:0] rdat_reg, rdat_next;
  logic [31:0] wval;
  logic wr_en;
  logic [$clog2(MS_CYCLES)-1:0] ms_cnt_reg, ms_cnt_next;
  logic [9:0] sec_div_reg, sec_div_next;
  logic [11:0] idle_reg, idle_next;
  logic ms_tick, sec_tick, panel_busy, timeout_hit;
  logic [2:0] lvl_reg [lac_pkg::NUM_SRC];
  logic [2:0] lvl_next [lac_pkg::NUM_SRC];
  logic lock_next;
  lac_dlg_t dlg_reg, dlg_next;
  logic [5:0] dpulse_next;
  logic [16:0] ind_prev, ack_vec, remote_vec, manual_vec, grp_vec, cmd_vec;
  logic [2:0] grp_prev;
  logic alarm_prev, clear_prev, remote_en;
  logic [1:0] opt;

  assign remote_en = ctrl_reg[lac_pkg::CTRL_REM_BIT];
  assign opt = ctrl_reg[lac_pkg::CTRL_OPT_LSB +: 2];
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && !ack_reg;

  // bus slave: one wait cycle, unmapped reads zero, writes ignored
  always_comb begin
    ack_next = wb_cyc_i && wb_stb_i && !ack_reg;
    rdat_next = rdat_reg;
    ctrl_next = ctrl_reg;
    tmo_next = tmo_reg;
    offdly_next = offdly_reg;
    cmd_next = 5'h00;
    wval = 32'h00000000;
    if (ack_next && !wb_we_i) begin
      case (wb_adr_i)
        lac_pkg::OFS_CTRL: rdat_next = ctrl_reg;
        lac_pkg::OFS_TMO: rdat_next = {20'h00000, tmo_reg};
        lac_pkg::OFS_OFFDLY: rdat_next = {16'h0000, offdly_reg};
        lac_pkg::OFS_STATUS: rdat_next = {13'h0000, dialog_active, lock_open, obj_out};
        lac_pkg::OFS_LEVELS: rdat_next = {17'h00000, lvl_reg[4], lvl_reg[3], lvl_reg[2],
                                          lvl_reg[1], lvl_reg[0]};
        default: rdat_next = 32'h00000000;
      endcase
    end
    if (wr_en) begin
      case (wb_adr_i)
        lac_pkg::OFS_CTRL: ctrl_next = merge(ctrl_reg, wb_dat_i, wb_sel_i)
                                       & lac_pkg::CTRL_WMASK;
        lac_pkg::OFS_TMO: begin
          wval = merge({20'h00000, tmo_reg}, wb_dat_i, wb_sel_i);
          // out-of-range values are clamped rather than refused
          if (wval < {20'h00000, lac_pkg::TMO_MIN_S}) tmo_next = lac_pkg::TMO_MIN_S;
          else if (wval > {20'h00000, lac_pkg::TMO_MAX_S}) tmo_next = lac_pkg::TMO_MAX_S;
          else tmo_next = wval[11:0];
        end
        lac_pkg::OFS_OFFDLY: begin
          wval = merge({16'h0000, offdly_reg}, wb_dat_i, wb_sel_i);
          offdly_next = wval[15:0]; // upper half has no storage
        end
        lac_pkg::OFS_CMD: cmd_next = wb_dat_i[4:0];
        default: cmd_next = 5'h00;
      endcase
    end
    // factory defaults restore every setting
    if (dpulse_next[0]) begin
      ctrl_next = lac_pkg::CTRL_RST;
      tmo_next = lac_pkg::TMO_RST_S;
      offdly_next = lac_pkg::OFFDLY_RST_MS;
    end
  end

  // time base and panel inactivity counter
  always_comb begin
    ms_tick = (ms_cnt_reg == $bits(ms_cnt_reg)'(MS_CYCLES - 1));
    ms_cnt_next = ms_tick ? '0 : ms_cnt_reg + 1'b1;
    sec_tick = ms_tick && (sec_div_reg == 10'(lac_pkg::MS_PER_SEC - 1));
    sec_div_next = sec_tick ? 10'h000 : (ms_tick ? sec_div_reg + 10'h001 : sec_div_reg);
    panel_busy = (lvl_reg[0] != lac_pkg::LV_RO) || edit_dirty;
    timeout_hit = panel_busy && !key_press && (idle_reg >= tmo_reg);
    if (key_press || !panel_busy || timeout_hit) idle_next = 12'h000;
    else if (sec_tick) idle_next = idle_reg + 12'h001;
    else idle_next = idle_reg;
  end

  // per-source access levels, each source separate
  always_comb begin
    for (int s = 0; s < lac_pkg::NUM_SRC; s++) begin
      lvl_next[s] = lvl_reg[s];
      if (unlock_req && unlock_src == 3'(s)) lvl_next[s] = unlock_area;
      if (lock_req && unlock_src == 3'(s)) lvl_next[s] = lac_pkg::LV_RO;
    end
    if (timeout_hit) lvl_next[0] = lac_pkg::LV_RO;
    lock_next = 1'b0;
    for (int s = 0; s < lac_pkg::NUM_SRC; s++) begin
      if (lvl_next[s] != lac_pkg::LV_RO) lock_next = 1'b1;
    end
    // a level covers its own area and those below it
    perm_grant = (perm_src < 3'(lac_pkg::NUM_SRC)) && permits(lvl_reg[perm_src], perm_area);
  end

  // reset dialog, reachable only from the panel clear key
  always_comb begin
    dlg_next = dlg_reg;
    dpulse_next = 6'h00;
    case (dlg_reg)
      DS_IDLE: begin
        if (cold_start && clear_key && opt != lac_pkg::OPT_OFF) dlg_next = DS_DIALOG;
        else if (cold_start) dlg_next = DS_DONE;
      end
      DS_DIALOG: begin
        if (dlg_factory_yes) begin
          dpulse_next = 6'h0f;
          dlg_next = DS_DONE;
        end else if (dlg_pw_yes && opt == lac_pkg::OPT_BOTH) begin
          dpulse_next = 6'h10;
          dlg_next = DS_DONE;
        end else if (dlg_exit) begin
          dlg_next = DS_DONE;
        end
      end
      DS_DONE: dlg_next = DS_DONE;
      default: dlg_next = DS_IDLE;
    endcase
    dpulse_next[5] = timeout_hit; // discard unsaved edits
  end

  // acknowledge sources; remote ones gated by remote enable
  always_comb begin
    cmd_vec = '0;
    if (cmd_reg[lac_pkg::CMD_LED]) cmd_vec = cmd_vec | lac_pkg::MASK_LED;
    if (cmd_reg[lac_pkg::CMD_BO]) cmd_vec = cmd_vec | lac_pkg::MASK_BO;
    if (cmd_reg[lac_pkg::CMD_SCADA]) cmd_vec = cmd_vec | lac_pkg::MASK_SCADA;
    if (cmd_reg[lac_pkg::CMD_TRIP]) cmd_vec = cmd_vec | lac_pkg::MASK_TRIP;
    if (cmd_reg[lac_pkg::CMD_ALL]) cmd_vec = '1;
    grp_vec = '0;
    if (ack_grp[0] && !grp_prev[0]) grp_vec = grp_vec | lac_pkg::MASK_LED;
    if (ack_grp[1] && !grp_prev[1]) grp_vec = grp_vec | lac_pkg::MASK_BO;
    if (ack_grp[2] && !grp_prev[2]) grp_vec = grp_vec | lac_pkg::MASK_SCADA;
    remote_vec = (ack_ind & ~ind_prev) | grp_vec | cmd_vec;
    if (prot_alarm && !alarm_prev) begin // leds only, never outputs or trip
      remote_vec[lac_pkg::NUM_LED-1:0] = remote_vec[lac_pkg::NUM_LED-1:0]
        | ctrl_reg[lac_pkg::CTRL_AUTO_LSB +: lac_pkg::NUM_LED];
    end
    // clear key is blocked while edits are pending or the reset dialog is open
    manual_vec = (clear_key && !clear_prev && !edit_dirty && dlg_reg != DS_DIALOG)
      ? '1 : '0;
    ack_vec = manual_vec | (remote_en ? remote_vec : '0);
  end

  // latch cells; only binary outputs use the off-delay
  for (genvar i = 0; i < lac_pkg::NUM_OBJ; i++) begin : g_obj
    lac_latch_cell u_cell (
      .mclk(mclk),
      .resetn(resetn),
      .src(obj_src[i]),
      .latch_en(ctrl_reg[lac_pkg::CTRL_LEN_LSB + i]),
      .ack(ack_vec[i]),
      .ms_tick(ms_tick),
      .use_dly(i >= lac_pkg::BO_LSB && i < lac_pkg::SCADA_LSB),
      .off_dly(offdly_reg),
      .out_q(obj_out[i])
    );
  end

  // registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrl_reg <= lac_pkg::CTRL_RST;
      tmo_reg <= lac_pkg::TMO_RST_S;
      offdly_reg <= lac_pkg::OFFDLY_RST_MS;
      cmd_reg <= 5'h00;
      ack_reg <= 1'b0;
      rdat_reg <= 32'h00000000;
      ms_cnt_reg <= '0;
      sec_div_reg <= 10'h000;
      idle_reg <= 12'h000;
      for (int s = 0; s < lac_pkg::NUM_SRC; s++) lvl_reg[s] <= lac_pkg::LV_RO;
      lock_open <= 1'b0;
      dlg_reg <= DS_IDLE;
      {edit_discard, pw_default, restart_req, counters_clear, records_clear,
       factory_defaults} <= 6'h00;
      ind_prev <= '0;
      grp_prev <= 3'h0;
      alarm_prev <= 1'b0;
      clear_prev <= 1'b0;
    end else begin
      ctrl_reg <= ctrl_next;
      tmo_reg <= tmo_next;
      offdly_reg <= offdly_next;
      cmd_reg <= cmd_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
      ms_cnt_reg <= ms_cnt_next;
      sec_div_reg <= sec_div_next;
      idle_reg <= idle_next;
      for (int s = 0; s < lac_pkg::NUM_SRC; s++) lvl_reg[s] <= lvl_next[s];
      lock_open <= lock_next;
      dlg_reg <= dlg_next;
      {edit_discard, pw_default, restart_req, counters_clear, records_clear,
       factory_defaults} <= dpulse_next;
      ind_prev <= ack_ind;
      grp_prev <= ack_grp;
      alarm_prev <= prot_alarm;
      clear_prev <= clear_key;
    end
  end

  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdat_reg;
  assign dialog_active = (dlg_reg == DS_DIALOG);

  sequence factory_confirm_s;
    dlg_reg == DS_DIALOG && dlg_factory_yes;
  endsequence
  sequence factory_effects_s;
    factory_defaults && records_clear && counters_clear && restart_req && !pw_default;
  endsequence

  factory_reset_a: assert property (@(posedge mclk) disable iff (!resetn)
    factory_confirm_s |=> factory_effects_s ##1 !restart_req)
    else $error("factory reset effects missing");
  pw_option_a: assert property (@(posedge mclk) disable iff (!resetn)
    pw_default |-> $past(opt) == lac_pkg::OPT_BOTH && $past(dlg_pw_yes))
    else $error("password reset despite option");
  dialog_entry_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(dialog_active) |-> $past(clear_key) && $past(cold_start))
    else $error("dialog opened without clear key at cold start");
  timeout_range_a: assert property (@(posedge mclk) disable iff (!resetn)
    tmo_reg >= lac_pkg::TMO_MIN_S && tmo_reg <= lac_pkg::TMO_MAX_S)
    else $error("inactivity timeout out of range");
  timeout_drop_a: assert property (@(posedge mclk) disable iff (!resetn)
    timeout_hit |=> lvl_reg[0] == lac_pkg::LV_RO && edit_discard)
    else $error("timeout did not return panel to read-only");
  session_isolate_a: assert property (@(posedge mclk) disable iff (!resetn)
    unlock_req && unlock_src != 3'h0 |=> lvl_reg[0] == $past(lvl_reg[0]) || $past(timeout_hit))
    else $error("session unlock changed panel level");
  lock_symbol_a: assert property (@(posedge mclk) disable iff (!resetn)
    (lvl_reg[0] != lac_pkg::LV_RO || lvl_reg[3] != lac_pkg::LV_RO) |-> lock_open)
    else $error("lock indication closed while unlocked");
  remote_gate_a: assert property (@(posedge mclk) disable iff (!resetn)
    !remote_en && !(clear_key && !clear_prev) |-> ack_vec == '0)
    else $error("remote acknowledge acted while disabled");
  auto_led_only_a: assert property (@(posedge mclk) disable iff (!resetn)
    $rose(prot_alarm) && cmd_reg == 5'h00 && grp_vec == '0 && ack_ind == ind_prev
      && !clear_key |-> ack_vec[16:8] == '0)
    else $error("alarm acknowledged a non-led object");
  bus_answer_a: assert property (@(posedge mclk) disable iff (!resetn)
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer not one cycle after request");
endmodule // lac_access_ack

/* File: lac_latch_cell.sv */
// one latched object with acknowledge and optional off-delay
// assumes ack is already gated and ms_tick is a one-cycle enable
`timescale 1ns/1ns
module lac_latch_cell (
  // clock and reset
  input wire logic mclk,
  input wire logic resetn,
  // object control
  input wire logic src,
  input wire logic latch_en,
  input wire logic ack,
  input wire logic ms_tick,
  input wire logic use_dly,
  input wire logic [15:0] off_dly,
  // object state
  output logic out_q
);
  logic latch_reg, latch_next;
  logic [15:0] dly_reg, dly_next;
  logic out_next;
  logic level;

  // latch and off-delay next state
  always_comb begin
    latch_next = latch_reg;
    dly_next = dly_reg;
    level = src | latch_reg;
    if (src && latch_en) begin
      latch_next = 1'b1;
    end else if (ack || !latch_en) begin
      latch_next = 1'b0; // acknowledged with source gone, or latching disabled here
    end
    // an ack while src is high is simply dropped, never queued
    if (level) begin
      dly_next = off_dly;
    end else if (dly_reg != 16'h0000 && ms_tick) begin
      dly_next = dly_reg - 16'h0001;
    end
    out_next = level | (use_dly && dly_reg != 16'h0000);
  end

  // registers
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      latch_reg <= 1'b0;
      dly_reg <= 16'h0000;
      out_q <= 1'b0;
    end else begin
      latch_reg <= latch_next;
      dly_reg <= dly_next;
      out_q <= out_next;
    end
  end

  clear_needs_idle_a: assert property (@(posedge mclk) disable iff (!resetn)
    $fell(latch_reg) |-> !$past(src))
    else $error("latch cleared while source active");
  ack_dropped_a: assert property (@(posedge mclk) disable iff (!resetn)
    (ack && src && latch_en) ##1 !src |-> latch_reg)
    else $error("ack during active source was not dropped");
  off_delay_hold_a: assert property (@(posedge mclk) disable iff (!resetn)
    (use_dly && dly_reg > 16'h0001) |=> out_q)
    else $error("output released before off-delay elapsed");
endmodule // lac_latch_cell

/* File: lac_panel_model.sv */
// local panel model: clear key presses and a cold boot with the key held
// assumes bench requests are one-cycle pulses synchronous to mclk
`timescale 1ns/1ns
module lac_panel_model #(
  parameter int HOLD = 4
) (
  // clock
  input wire logic mclk,
  // requests from the bench
  input wire logic press_req,
  input wire logic boot_req,
  // panel lines
  output logic clear_key,
  output logic cold_start
);
  int cnt;
  logic booting;
  initial begin
    clear_key = 1'b0;
    cold_start = 1'b0;
    cnt = 0;
    booting = 1'b0;
  end
  // key held for a few cycles; a press is seen as the rising edge
  always @(posedge mclk) begin
    if (press_req) cnt <= HOLD;
    else if (boot_req) cnt <= 3 * HOLD; // key held across the boot pulse
    else if (cnt > 0) cnt <= cnt - 1;
    if (boot_req) booting <= 1'b1;
    else if (cnt == 0) booting <= 1'b0;
    clear_key <= (cnt > 1);
    // boot pulse lands mid-hold so the key is surely down when sampled
    cold_start <= booting && (cnt == 2 * HOLD);
  end
endmodule // lac_panel_model

/* File: lac_pkg.sv */
// constants shared by the latch/acknowledge and access control block
// assumes a single 50 MHz clock and a classic wishbone register port
package lac_pkg;
  // clock and time base
  localparam int CLK_PERIOD_NS = 20;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int MS_PER_SEC = 1000;
  // inactivity timeout limits and reset value, seconds; off-delay reset value, ms
  localparam logic [11:0] TMO_MIN_S = 12'd20;
  localparam logic [11:0] TMO_MAX_S = 12'd3600;
  localparam logic [11:0] TMO_RST_S = 12'd600;
  localparam logic [15:0] OFFDLY_RST_MS = 16'h0000;
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_TMO = 8'h04;
  localparam logic [7:0] OFS_OFFDLY = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0c;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_LEVELS = 8'h14;
  // ctrl fields
  localparam int CTRL_REM_BIT = 0;
  localparam int CTRL_OPT_LSB = 1;
  localparam int CTRL_LEN_LSB = 4;
  localparam int CTRL_AUTO_LSB = 21;
  localparam logic [31:0] CTRL_RST = 32'h001ffff1;
  localparam logic [31:0] CTRL_WMASK = 32'h1ffffff7;
  // collective command bits
  localparam int CMD_LED = 0;
  localparam int CMD_BO = 1;
  localparam int CMD_SCADA = 2;
  localparam int CMD_TRIP = 3;
  localparam int CMD_ALL = 4;
  // latched objects: leds, binary outputs, scada signals, trip command
  localparam int NUM_OBJ = 17;
  localparam int NUM_LED = 8;
  localparam int BO_LSB = 8;
  localparam int SCADA_LSB = 12;
  localparam int TRIP_BIT = 16;
  localparam logic [16:0] MASK_LED = 17'h000ff;
  localparam logic [16:0] MASK_BO = 17'h00f00;
  localparam logic [16:0] MASK_SCADA = 17'h0f000;
  localparam logic [16:0] MASK_TRIP = 17'h10000;
  // access sources: 0 is the panel, 1..4 remote sessions
  localparam int NUM_SRC = 5;
  typedef enum logic [2:0] {
    LV_RO, LV_P1, LV_P2, LV_C1, LV_C2, LV_S3
  } lac_level_t;
  // reset dialog options
  typedef enum logic [1:0] {
    OPT_BOTH, OPT_FACTORY, OPT_OFF
  } lac_opt_t;
endpackage

/* File: tb_lac_access_ack.sv */
// self-checking bench for the latch/acknowledge and access control block
// assumes the design answers wishbone requests and MS_CYCLES is shortened to 2
`timescale 1ns/1ns
module tb_lac_access_ack;
  logic mclk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
  logic wb_ack_o, key_press = 1'b0, clear_key, edit_dirty = 1'b0, cold_start;
  logic dlg_factory_yes = 1'b0, dlg_pw_yes = 1'b0, dlg_exit = 1'b0, dialog_active;
  logic factory_defaults, records_clear, counters_clear, restart_req, pw_default;
  logic edit_discard, lock_open, unlock_req = 1'b0, lock_req = 1'b0, perm_grant;
  logic [2:0] unlock_src = 3'h0, unlock_area = 3'h0, perm_src = 3'h0, perm_area = 3'h0;
  logic [16:0] obj_src = 17'h0, ack_ind = 17'h0, obj_out;
  logic [2:0] ack_grp = 3'h0;
  logic prot_alarm = 1'b0, press_req = 1'b0, boot_req = 1'b0;
  logic pw_seen = 1'b0, fac_seen = 1'b0, disc_seen = 1'b0;
  int fail_count = 0, tests_run = 0;
  int idx [5] = '{3, 9, 13, 16, 0};

  always #10 mclk = ~mclk;

  lac_access_ack #(.MS_CYCLES(2)) u_lac_access_ack (.mclk(mclk), .resetn(resetn),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .key_press(key_press), .clear_key(clear_key), .edit_dirty(edit_dirty),
    .cold_start(cold_start), .dlg_factory_yes(dlg_factory_yes), .dlg_pw_yes(dlg_pw_yes),
    .dlg_exit(dlg_exit), .dialog_active(dialog_active), .factory_defaults(factory_defaults),
    .records_clear(records_clear), .counters_clear(counters_clear),
    .restart_req(restart_req), .pw_default(pw_default), .edit_discard(edit_discard),
    .lock_open(lock_open), .unlock_req(unlock_req), .lock_req(lock_req),
    .unlock_src(unlock_src), .unlock_area(unlock_area), .perm_src(perm_src),
    .perm_area(perm_area), .perm_grant(perm_grant), .obj_src(obj_src), .ack_ind(ack_ind),
    .ack_grp(ack_grp), .prot_alarm(prot_alarm), .obj_out(obj_out));

  lac_panel_model u_lac_panel_model (.mclk(mclk), .press_req(press_req),
    .boot_req(boot_req), .clear_key(clear_key), .cold_start(cold_start));

  // sticky catch of one-cycle pulses
  always @(posedge mclk) begin
    if (pw_default === 1'b1) pw_seen <= 1'b1;
    if ((factory_defaults & records_clear & counters_clear & restart_req) === 1'b1)
      fac_seen <= 1'b1;
    if (edit_discard === 1'b1) disc_seen <= 1'b1;
  end

  task automatic summarize();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // classic single wishbone cycle; waits for ack under a bound
  task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge mclk);
    wb_cyc_i <= 1'b1; wb_stb_i <= 1'b1; wb_we_i <= we;
    wb_adr_i <= a; wb_dat_i <= d; wb_sel_i <= 4'hf;
    for (k = 0; k < 50; k++) begin
      @(posedge mclk);
      if (wb_ack_o === 1'b1) break;
    end
    rd = wb_dat_o;
    wb_cyc_i <= 1'b0; wb_stb_i <= 1'b0; wb_we_i <= 1'b0;
    if (k == 50) begin
      fail_count++;
      summarize();
    end
  endtask

  task automatic rchk(input string n, input logic [7:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(n, e, rd);
  endtask

  task automatic do_reset();
    resetn <= 1'b0;
    cyc(5);
    resetn <= 1'b1;
    pw_seen = 1'b0; fac_seen = 1'b0;
    cyc(1);
  endtask

  task automatic access(input logic un, input logic [2:0] s, input logic [2:0] a);
    unlock_req <= un; lock_req <= !un; unlock_src <= s; unlock_area <= a;
    cyc(1);
    unlock_req <= 1'b0; lock_req <= 1'b0;
    cyc(2);
  endtask

  task automatic perm(input logic [2:0] s, input logic [2:0] a, input logic e);
    perm_src <= s; perm_area <= a;
    cyc(1);
    chk("perm_grant", {31'h0, e}, {31'h0, perm_grant});
  endtask

  task automatic pulse(input int which);
    if (which == 0) press_req <= 1'b1; else if (which == 1) boot_req <= 1'b1;
    else if (which == 2) dlg_pw_yes <= 1'b1; else dlg_factory_yes <= 1'b1;
    cyc(1);
    press_req <= 1'b0; boot_req <= 1'b0; dlg_pw_yes <= 1'b0; dlg_factory_yes <= 1'b0;
    cyc(16);
  endtask

  // bounded wait for one latch output to reach a level
  task automatic wait_out(input int i, input logic v, input int lim);
    for (int k = 0; k < lim && obj_out[i] !== v; k++) @(posedge mclk);
    chk("obj_out bit", {31'h0, v}, {31'h0, obj_out[i]});
  endtask

  // set a group of sources for a few cycles, then release them
  task automatic set_src(input logic [16:0] m);
    obj_src <= m;
    cyc(3);
    obj_src <= 17'h0;
  endtask

  initial begin
    do_reset();
    rchk("ctrl", 8'h00, 32'h001ffff1);
    rchk("tmo", 8'h04, 32'h00000258);
    rchk("offdly", 8'h08, 32'h0);
    rchk("unmapped", 8'h18, 32'h0);
    // reset dialog under each option: both, factory only, disabled
    pulse(1);
    chk("dialog", 32'h1, {31'h0, dialog_active});
    pulse(2);
    chk("pw reset", 32'h1, {31'h0, pw_seen});
    do_reset();
    wb(1'b1, 8'h00, 32'h001ffff3);
    pulse(1);
    chk("dialog", 32'h1, {31'h0, dialog_active});
    pulse(2);
    chk("pw reset", 32'h0, {31'h0, pw_seen});
    pulse(3);
    chk("factory", 32'h1, {31'h0, fac_seen});
    rchk("ctrl", 8'h00, 32'h001ffff1);
    do_reset();
    wb(1'b1, 8'h00, 32'h001ffff5);
    pulse(1);
    chk("dialog", 32'h0, {31'h0, dialog_active});
    wb(1'b1, 8'h00, 32'h001ffff1);
    // session unlock stays with that session
    access(1'b1, 3'h2, 3'h2);
    rchk("levels", 8'h14, 32'h00000080);
    chk("lock_open", 32'h1, {31'h0, lock_open});
    rchk("status", 8'h10, 32'h00020000);
    perm(3'h2, 3'h1, 1'b1);
    perm(3'h2, 3'h3, 1'b0);
    perm(3'h0, 3'h1, 1'b0);
    perm(3'h1, 3'h1, 1'b0);
    access(1'b0, 3'h2, 3'h0);
    chk("lock_open", 32'h0, {31'h0, lock_open});
    // manual ack only once the source has gone
    obj_src[0] <= 1'b1;
    cyc(3);
    chk("latch", 32'h1, {31'h0, obj_out[0]});
    pulse(0);
    chk("latch", 32'h1, {31'h0, obj_out[0]});
    obj_src[0] <= 1'b0;
    cyc(4);
    chk("latch", 32'h1, {31'h0, obj_out[0]});
    pulse(0);
    chk("latch", 32'h0, {31'h0, obj_out[0]});
    // remote kinds blocked while remote enable is off
    wb(1'b1, 8'h00, 32'h001ffff0);
    set_src(17'h00002);
    ack_ind[1] <= 1'b1;
    cyc(2);
    ack_ind[1] <= 1'b0;
    wb(1'b1, 8'h0c, 32'h00000010);
    cyc(4);
    chk("latch", 32'h1, {31'h0, obj_out[1]});
    wb(1'b1, 8'h00, 32'h003ffff1);
    wb(1'b1, 8'h08, 32'h00000014);
    ack_ind[1] <= 1'b1;
    cyc(2);
    ack_ind[1] <= 1'b0;
    wait_out(1, 1'b0, 6);
    // alarm clears only auto-ack leds
    set_src(17'h00105);
    cyc(3);
    prot_alarm <= 1'b1;
    cyc(2);
    prot_alarm <= 1'b0;
    cyc(4);
    chk("alarm ack", 32'h00104, {15'h0, obj_out & 17'h00105});
    ack_grp[0] <= 1'b1;
    cyc(2);
    ack_grp[0] <= 1'b0;
    wait_out(2, 1'b0, 6);
    set_src(17'h00100);
    ack_grp[1] <= 1'b1;
    cyc(2);
    ack_grp[1] <= 1'b0;
    cyc(4);
    chk("bo hold", 32'h1, {31'h0, obj_out[8]});
    wait_out(8, 1'b0, 100);
    // each collective command, then the all command
    for (int g = 0; g < 5; g++) begin
      set_src(17'h1220a);
      cyc(3);
      wb(1'b1, 8'h0c, 32'h1 << g);
      if (g < 4) wait_out(idx[g], 1'b0, 100);
      else for (int j = 0; j < 4; j++) wait_out(idx[j], 1'b0, 100);
    end
    // panel inactivity timeout with clamped limits
    wb(1'b1, 8'h04, 32'h00000fa0);
    rchk("tmo max", 8'h04, 32'h00000e10);
    wb(1'b1, 8'h04, 32'h00000005);
    rchk("tmo min", 8'h04, 32'h00000014);
    access(1'b1, 3'h0, 3'h1);
    cyc(20000);
    key_press <= 1'b1;
    cyc(1);
    key_press <= 1'b0;
    cyc(37000);
    chk("lock_open", 32'h1, {31'h0, lock_open});
    for (int k = 0; k < 5000 && lock_open !== 1'b0; k++) @(posedge mclk);
    cyc(3);
    chk("lock_open", 32'h0, {31'h0, lock_open});
    chk("discard", 32'h1, {31'h0, disc_seen});
    summarize();
  end
endmodule // tb_lac_access_ack
